//--- rtl/cpu_sfr_pkg.sv
package cpu_sfr_pkg;

  // Register addresses on the special function register port.
  localparam logic [7:0] ADDR_CODE_BANK = 8'ha1;
  localparam logic [7:0] ADDR_CODE_MAP  = 8'hc0;
  localparam logic [7:0] ADDR_PSW       = 8'hd0;
  localparam logic [7:0] ADDR_ACC       = 8'he0;
  localparam logic [7:0] ADDR_AUX       = 8'hf0;

  // Field positions.
  localparam int MAP_DLBOOT_BIT = 2;
  localparam int MAP_UPPER_BIT  = 1;
  localparam int BANK_SEL_BIT   = 0;
  localparam int PSW_CY_BIT     = 7;
  localparam int PSW_AC_BIT     = 6;
  localparam int PSW_F0_BIT     = 5;
  localparam int PSW_RS_HI      = 4;
  localparam int PSW_RS_LO      = 3;
  localparam int PSW_OV_BIT     = 2;
  localparam int PSW_F1_BIT     = 1;
  localparam int PSW_P_BIT      = 0;

  // Reset values.
  localparam logic [7:0] RST_ACC       = 8'h00;
  localparam logic [7:0] RST_AUX       = 8'h00;
  localparam logic       RST_FLAG      = 1'b0;
  localparam logic [1:0] RST_RS        = 2'h0;
  localparam logic       RST_UPPER_MAP = 1'b1;
  localparam logic       RST_CODE_BANK = 1'b0;
  localparam logic [7:0] RDATA_IDLE    = 8'h00;

  // Strap code that marks download boot, and the boot ROM window.
  localparam logic [1:0]  STRAP_DOWNLOAD    = 2'h3;
  localparam logic [15:0] UPPER_REGION_BASE = 16'hfc00;

  // Multiply and divide sequencer states.
  typedef enum logic [0:0] {
    MD_IDLE = 1'b0,
    MD_DONE = 1'b1
  } md_state_t;

  function automatic logic odd_parity(input logic [7:0] v);
    return ^v;
  endfunction

endpackage

//--- rtl/code_fetch_map.sv
`timescale 1ns/10ps
module code_fetch_map
  import cpu_sfr_pkg::*;
(
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        reset,
  // Fetch request.
  input  wire logic        fetch_valid,
  input  wire logic [15:0] fetch_addr,
  input  wire logic        upper_code_rom_map,
  input  wire logic        code_bank_select,
  // Fetch routing, one cycle later.
  output logic             fetch_done,
  output logic             fetch_from_boot_rom,
  output logic             fetch_code_bank
);

  typedef struct packed {
    logic done;
    logic boot;
    logic bank;
  } fetch_state_t;

  fetch_state_t st_q;
  fetch_state_t st_d;

  function automatic logic in_upper_region(input logic [15:0] a);
    return a >= UPPER_REGION_BASE;
  endfunction

  always_comb begin
    st_d      = st_q;
    st_d.done = fetch_valid;
    if (fetch_valid) begin
      // The boot ROM overlays only the top region; all else goes to flash.
      st_d.boot = upper_code_rom_map && in_upper_region(fetch_addr);
      st_d.bank = code_bank_select;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_q <= '{done: 1'b0, boot: 1'b0, bank: RST_CODE_BANK};
    end else begin
      st_q <= st_d;
    end
  end

  assign fetch_done          = st_q.done;
  assign fetch_from_boot_rom = st_q.boot;
  assign fetch_code_bank     = st_q.bank;

endmodule

//--- rtl/mul_div_unit.sv
`timescale 1ns/10ps
module mul_div_unit
  import cpu_sfr_pkg::*;
(
  // Clock and reset.
  input  wire logic       mclk,
  input  wire logic       reset,
  // Operation request.
  input  wire logic       start,
  input  wire logic       is_div,
  input  wire logic [7:0] acc_in,
  input  wire logic [7:0] aux_in,
  // Result, valid while done is high.
  output logic            done,
  output logic [7:0]      acc_out,
  output logic [7:0]      aux_out,
  output logic            ovf
);

  typedef struct packed {
    md_state_t  state;
    logic [7:0] acc;
    logic [7:0] aux;
    logic       ovf;
  } md_regs_t;

  md_regs_t st_q;
  md_regs_t st_d;

  always_comb begin
    logic [15:0] prod;
    prod       = 16'h0000;
    st_d       = st_q;
    st_d.state = MD_IDLE;
    if (start) begin
      st_d.state = MD_DONE;
      if (!is_div) begin
        prod     = acc_in * aux_in;
        st_d.acc = prod[7:0];
        st_d.aux = prod[15:8];
        st_d.ovf = |prod[15:8];
      end else if (acc_in == 8'h00) begin
        // A zero divisor leaves both operands untouched and flags overflow.
        st_d.acc = acc_in;
        st_d.aux = aux_in;
        st_d.ovf = 1'b1;
      end else begin
        st_d.acc = aux_in / acc_in;
        st_d.aux = aux_in % acc_in;
        st_d.ovf = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_q <= '{state: MD_IDLE, acc: RST_ACC, aux: RST_AUX, ovf: RST_FLAG};
    end else begin
      st_q <= st_d;
    end
  end

  always_comb begin
    case (st_q.state)
      MD_IDLE: done = 1'b0;
      MD_DONE: done = 1'b1;
      default: done = 1'b0;
    endcase
  end

  assign acc_out = st_q.acc;
  assign aux_out = st_q.aux;
  assign ovf     = st_q.ovf;

endmodule

//--- rtl/cpu_core_status_and_code_map_regs.sv
`timescale 1ns/10ps
module cpu_core_status_and_code_map_regs
  import cpu_sfr_pkg::*;
(
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        reset,
  // Register port.
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  // Boot straps.
  input  wire logic [1:0]  boot_strap_pins,
  // Code fetch routing.
  input  wire logic        fetch_valid,
  input  wire logic [15:0] fetch_addr,
  output logic             fetch_done,
  output logic             fetch_from_boot_rom,
  output logic             fetch_code_bank,
  // Working register addressing.
  input  wire logic [2:0]  gpr_index,
  output logic [4:0]       gpr_addr,
  // Multiply and divide.
  input  wire logic        muldiv_start,
  input  wire logic        muldiv_is_div,
  output logic             muldiv_done,
  // Status.
  output logic [7:0]       accumulator,
  output logic [7:0]       mul_div_aux,
  output logic             acc_parity,
  output logic             upper_code_rom_map,
  output logic             code_bank_select,
  output logic             download_boot_flag
);

  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] aux;
    logic       cy;
    logic       ac;
    logic       f0;
    logic [1:0] rs;
    logic       ov;
    logic       f1;
    logic       par;
    logic       upper_map;
    logic       bank;
    logic       dlboot;
    logic [7:0] rdata;
  } core_state_t;

  core_state_t st_q;
  core_state_t st_d;

  logic       md_done;
  logic [7:0] md_acc;
  logic [7:0] md_aux;
  logic       md_ovf;

  mul_div_unit u_mul_div (
    .mclk    (mclk),
    .reset   (reset),
    .start   (muldiv_start),
    .is_div  (muldiv_is_div),
    .acc_in  (st_q.acc),
    .aux_in  (st_q.aux),
    .done    (md_done),
    .acc_out (md_acc),
    .aux_out (md_aux),
    .ovf     (md_ovf)
  );

  code_fetch_map u_fetch_map (
    .mclk                (mclk),
    .reset               (reset),
    .fetch_valid         (fetch_valid),
    .fetch_addr          (fetch_addr),
    .upper_code_rom_map  (st_q.upper_map),
    .code_bank_select    (st_q.bank),
    .fetch_done          (fetch_done),
    .fetch_from_boot_rom (fetch_from_boot_rom),
    .fetch_code_bank     (fetch_code_bank)
  );

  function automatic logic [7:0] read_value(input core_state_t s, input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      ADDR_CODE_BANK: v[BANK_SEL_BIT] = s.bank;
      ADDR_CODE_MAP: begin
        v[MAP_DLBOOT_BIT] = s.dlboot;
        v[MAP_UPPER_BIT]  = s.upper_map;
      end
      ADDR_PSW: v = {s.cy, s.ac, s.f0, s.rs, s.ov, s.f1, s.par};
      ADDR_ACC: v = s.acc;
      ADDR_AUX: v = s.aux;
      default:  v = 8'h00;
    endcase
    return v;
  endfunction

  always_comb begin
    st_d = st_q;

    // The flag follows the straps every cycle; software cannot write it.
    st_d.dlboot = (boot_strap_pins == STRAP_DOWNLOAD);

    if (reg_wr) begin
      case (reg_addr)
        ADDR_CODE_BANK: st_d.bank = reg_wdata[BANK_SEL_BIT];
        ADDR_CODE_MAP:  st_d.upper_map = reg_wdata[MAP_UPPER_BIT];
        ADDR_PSW: begin
          st_d.cy = reg_wdata[PSW_CY_BIT];
          st_d.ac = reg_wdata[PSW_AC_BIT];
          st_d.f0 = reg_wdata[PSW_F0_BIT];
          st_d.rs = reg_wdata[PSW_RS_HI:PSW_RS_LO];
          st_d.ov = reg_wdata[PSW_OV_BIT];
          st_d.f1 = reg_wdata[PSW_F1_BIT];
        end
        ADDR_ACC: st_d.acc = reg_wdata;
        ADDR_AUX: st_d.aux = reg_wdata;
        default:  st_d.acc = st_d.acc;
      endcase
    end

    // An arithmetic result lands after any software write in the same cycle,
    // since the instruction retiring is the later event in program order.
    if (md_done) begin
      st_d.acc = md_acc;
      st_d.aux = md_aux;
      st_d.cy  = 1'b0;
      st_d.ov  = md_ovf;
    end

    // Parity is derived from the next accumulator so it never lags a cycle.
    st_d.par   = odd_parity(st_d.acc);
    st_d.rdata = reg_rd ? read_value(st_q, reg_addr) : RDATA_IDLE;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_q <= '{acc: RST_ACC, aux: RST_AUX, cy: RST_FLAG, ac: RST_FLAG, f0: RST_FLAG,
                rs: RST_RS, ov: RST_FLAG, f1: RST_FLAG, par: RST_FLAG,
                upper_map: RST_UPPER_MAP, bank: RST_CODE_BANK, dlboot: RST_FLAG,
                rdata: RDATA_IDLE};
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata          = st_q.rdata;
  assign gpr_addr           = {st_q.rs, gpr_index};
  assign muldiv_done        = md_done;
  assign accumulator        = st_q.acc;
  assign mul_div_aux        = st_q.aux;
  assign acc_parity         = st_q.par;
  assign upper_code_rom_map = st_q.upper_map;
  assign code_bank_select   = st_q.bank;
  assign download_boot_flag = st_q.dlboot;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  sequence mul_go;
    muldiv_start && !muldiv_is_div && !reset;
  endsequence

  sequence div_go;
    muldiv_start && muldiv_is_div && (st_q.acc != 8'h00) && !reset;
  endsequence

  a_strap_flag: assert property (
    (boot_strap_pins == STRAP_DOWNLOAD) |=> download_boot_flag
  ) else $error("download flag missed strap code");

  a_strap_clear: assert property (
    (boot_strap_pins != STRAP_DOWNLOAD) |=> !download_boot_flag
  ) else $error("download flag set without strap code");

  // The flag is registered, so a read sees the straps of the cycle before the strobe.
  a_flag_readback: assert property (
    (boot_strap_pins == STRAP_DOWNLOAD) ##1 (reg_rd && reg_addr == ADDR_CODE_MAP)
      |=> reg_rdata[MAP_DLBOOT_BIT]
  ) else $error("map register read lost download flag");

  a_boot_fetch: assert property (
    (fetch_valid && fetch_addr >= UPPER_REGION_BASE)
      |=> (fetch_from_boot_rom == $past(upper_code_rom_map))
  ) else $error("upper region fetch routed wrongly");

  a_low_fetch: assert property (
    (fetch_valid && fetch_addr < UPPER_REGION_BASE) |=> fetch_done && !fetch_from_boot_rom
  ) else $error("low fetch served from boot rom");

  a_bank_write: assert property (
    (reg_wr && reg_addr == ADDR_CODE_BANK)
      |=> (code_bank_select == $past(reg_wdata[BANK_SEL_BIT]))
  ) else $error("code bank select not applied");

  a_fetch_bank: assert property (
    fetch_valid |=> (fetch_code_bank == $past(code_bank_select))
  ) else $error("fetch did not carry the selected bank");

  a_work_bank: assert property (
    (reg_wr && reg_addr == ADDR_PSW)
      |=> (gpr_addr[4:3] == $past(reg_wdata[PSW_RS_HI:PSW_RS_LO]))
  ) else $error("working bank not taken from status word");

  a_parity_live: assert property (
    acc_parity == odd_parity(accumulator)
  ) else $error("parity flag out of step with accumulator");

  a_mul_result: assert property (
    mul_go |-> ##2 ({mul_div_aux, accumulator} == $past(st_q.acc, 2) * $past(st_q.aux, 2))
  ) else $error("multiply product misplaced");

  a_div_result: assert property (
    div_go |-> ##2 (accumulator == $past(st_q.aux, 2) / $past(st_q.acc, 2)
                    && mul_div_aux == $past(st_q.aux, 2) % $past(st_q.acc, 2))
  ) else $error("divide remainder not left in aux");

  a_map_reserved: assert property (
    (reg_rd && reg_addr == ADDR_CODE_MAP) |=> (reg_rdata[7:3] == 5'h00 && !reg_rdata[0])
  ) else $error("map register reserved bits not zero");

  a_bank_reserved: assert property (
    (reg_rd && reg_addr == ADDR_CODE_BANK) |=> (reg_rdata[7:1] == 7'h00)
  ) else $error("bank register reserved bits not zero");

  a_read_once: assert property (
    !reg_rd |=> (reg_rdata == RDATA_IDLE)
  ) else $error("read data held past its cycle");

endmodule

//--- verification/cpu_core_status_and_code_map_regs_bench.sv
`timescale 1ns/10ps
module cpu_core_status_and_code_map_regs_bench;
  import cpu_sfr_pkg::*;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rexp;
  } row_t;

  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic [1:0]  boot_strap_pins = 2'h0;
  logic        fetch_valid = 1'b0;
  logic [15:0] fetch_addr = 16'h0000;
  logic        fetch_done;
  logic        fetch_from_boot_rom;
  logic        fetch_code_bank;
  logic [2:0]  gpr_index = 3'h0;
  logic [4:0]  gpr_addr;
  logic        muldiv_start = 1'b0;
  logic        muldiv_is_div = 1'b0;
  logic        muldiv_done;
  logic [7:0]  accumulator;
  logic [7:0]  mul_div_aux;
  logic        acc_parity;
  logic        upper_code_rom_map;
  logic        code_bank_select;
  logic        download_boot_flag;
  int          failures = 0;
  int          comparisons = 0;
  logic [7:0]  v;

  // Rows run in order, so the second status word expectation depends on the accumulator row before it.
  row_t rows [9] = '{
    '{8'ha1, 8'hff, 8'h01},
    '{8'ha1, 8'h00, 8'h00},
    '{8'hc0, 8'hff, 8'h02},
    '{8'hc0, 8'h00, 8'h00},
    '{8'hd0, 8'h1f, 8'h1e},
    '{8'he0, 8'h07, 8'h07},
    '{8'hd0, 8'h00, 8'h01},
    '{8'hf0, 8'ha5, 8'ha5},
    '{8'h55, 8'hab, 8'h00}
  };
  logic [7:0] rst_addr [5] = '{8'ha1, 8'hc0, 8'hd0, 8'he0, 8'hf0};
  logic [7:0] rst_exp  [5] = '{8'h00, 8'h02, 8'h00, 8'h00, 8'h00};

  always #2.5 mclk = ~mclk;

  cpu_core_status_and_code_map_regs u_cpu_core_status_and_code_map_regs (
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .boot_strap_pins(boot_strap_pins), .fetch_valid(fetch_valid),
    .fetch_addr(fetch_addr), .fetch_done(fetch_done),
    .fetch_from_boot_rom(fetch_from_boot_rom), .fetch_code_bank(fetch_code_bank),
    .gpr_index(gpr_index), .gpr_addr(gpr_addr), .muldiv_start(muldiv_start),
    .muldiv_is_div(muldiv_is_div), .muldiv_done(muldiv_done),
    .accumulator(accumulator), .mul_div_aux(mul_div_aux), .acc_parity(acc_parity),
    .upper_code_rom_map(upper_code_rom_map), .code_bank_select(code_bank_select),
    .download_boot_flag(download_boot_flag)
  );

  task automatic wrap_up();
    if (failures == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just past that edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic fetch(input logic [15:0] a, input logic boot, input logic bank);
    @(posedge mclk);
    fetch_valid <= 1'b1;
    fetch_addr <= a;
    @(posedge mclk);
    fetch_valid <= 1'b0;
    #1 chk("fetch", {13'h0, 1'b1, boot, bank},
           {13'h0, fetch_done, fetch_from_boot_rom, fetch_code_bank});
  endtask

  task automatic md(input logic dv, input logic [7:0] a, input logic [7:0] b,
                    input logic [15:0] exp, input logic ov);
    logic [7:0] p;
    wr(ADDR_ACC, a);
    wr(ADDR_AUX, b);
    @(posedge mclk);
    muldiv_start <= 1'b1;
    muldiv_is_div <= dv;
    @(posedge mclk);
    muldiv_start <= 1'b0;
    #1 chk("muldiv_done", 16'h1, {15'h0, muldiv_done});
    @(posedge mclk);
    #1 chk("aux_acc", exp, {mul_div_aux, accumulator});
    rd(ADDR_PSW, p);
    chk("cy_ov", {14'h0, 1'b0, ov}, {14'h0, p[7], p[2]});
  endtask

  initial begin
    repeat (3000) @(posedge mclk);
    failures++;
    wrap_up();
  end

  initial begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      rd(rst_addr[i], v);
      chk("reset value", {8'h0, rst_exp[i]}, {8'h0, v});
    end
    for (int i = 0; i < 9; i++) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, v);
      chk("readback", {8'h0, rows[i].rexp}, {8'h0, v});
    end
    // Boot window boundaries on both sides of the upper 1KB.
    wr(ADDR_CODE_MAP, 8'h02);
    fetch(16'hfc00, 1'b1, 1'b0);
    fetch(16'hfbff, 1'b0, 1'b0);
    fetch(16'hffff, 1'b1, 1'b0);
    wr(ADDR_CODE_BANK, 8'h01);
    fetch(16'h1234, 1'b0, 1'b1);
    wr(ADDR_CODE_MAP, 8'h00);
    fetch(16'hfc00, 1'b0, 1'b1);
    for (int i = 0; i < 4; i++) begin
      gpr_index <= 3'(7 - i);
      wr(ADDR_PSW, 8'(i << 3));
      #1 chk("gpr_addr", {11'h0, 2'(i), 3'(7 - i)}, {11'h0, gpr_addr});
    end
    for (int i = 0; i < 5; i++) begin
      // Values 0..4 give both parities, so a stuck flag cannot pass.
      wr(ADDR_ACC, 8'(i));
      #1 chk("acc_parity", {15'h0, ^3'(i)}, {15'h0, acc_parity});
    end
    boot_strap_pins <= 2'h3;
    rd(ADDR_CODE_MAP, v);
    chk("straps three", 16'h0104, {7'h0, download_boot_flag, v});
    boot_strap_pins <= 2'h2;
    rd(ADDR_CODE_MAP, v);
    chk("straps two", 16'h0000, {7'h0, download_boot_flag, v});
    md(1'b0, 8'h10, 8'h20, 16'h0200, 1'b1);
    md(1'b0, 8'h03, 8'h04, 16'h000c, 1'b0);
    md(1'b0, 8'hff, 8'hff, 16'hfe01, 1'b1);
    md(1'b1, 8'h07, 8'h64, 16'h020e, 1'b0);
    md(1'b1, 8'h00, 8'h33, 16'h3300, 1'b1);
    // A second reset in mid-run must restore the documented defaults.
    wr(ADDR_ACC, 8'h5b);
    wr(ADDR_CODE_BANK, 8'h01);
    @(posedge mclk);
    reset <= 1'b1;
    @(posedge mclk);
    reset <= 1'b0;
    #1 chk("second reset", 16'h0002,
           {accumulator, 4'h0, acc_parity, code_bank_select, upper_code_rom_map, 1'b0});
    wrap_up();
  end
endmodule
